// ==== rtl/cbr_pair_ctl.sv ====
// Drive control of one differential clock output pair
`timescale 1ns/1ns
module cbr_pair_ctl
  import cbr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [1:0] disabled_output_level,
  output logic pass,
  output logic true_lvl,
  output logic comp_lvl,
  output logic hiz
);
  // Disabled pair takes the programmed static level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pass <= 1'b0;
      true_lvl <= 1'b0;
      comp_lvl <= 1'b0;
      hiz <= 1'b0;
    end else begin
      pass <= enable;
      hiz <= !enable && (disabled_output_level == LVL_HIZ); // [R12]
      case (disabled_output_level)
        LVL_HIGH_LOW: begin
          true_lvl <= 1'b1;
          comp_lvl <= 1'b0;
        end
        LVL_LOW_HIGH: begin
          true_lvl <= 1'b0;
          comp_lvl <= 1'b1;
        end
        default: begin
          true_lvl <= 1'b0;
          comp_lvl <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ==== rtl/cbr_pkg.sv ====
// Shared constants for the clock buffer configuration register bank
package cbr_pkg;
  // Byte addresses held by this bank
  localparam logic [7:0] ADDR_EDGE_RATE = 8'h03;
  localparam logic [7:0] ADDR_RSVD_ONES = 8'h04;
  localparam logic [7:0] ADDR_REV_VENDOR = 8'h05;
  localparam logic [7:0] ADDR_CLASS_PART = 8'h06;
  localparam logic [7:0] ADDR_READBACK_LEN = 8'h07;
  localparam logic [7:0] ADDR_RSVD_EIGHT = 8'h08;
  localparam logic [7:0] ADDR_RSVD_NINE = 8'h09;
  localparam logic [7:0] ADDR_PD_RETAIN = 8'h0A;
  localparam logic [7:0] ADDR_IMP_LEVEL = 8'h0B;
  localparam logic [7:0] ADDR_IMP_LOW = 8'h0C;

  // Field positions
  localparam int EDGE6_BIT = 0;
  localparam int RETAIN_BIT = 6;
  localparam int LEN_MSB = 4;
  localparam int LEVEL_MSB = 1;
  localparam int IMP6_LSB = 6;
  localparam int IMP2_LSB = 6;
  localparam int IMP1_LSB = 4;
  localparam int IMP0_LSB = 0;

  // Reset values and fixed read patterns
  localparam logic EDGE6_RESET = 1'b1;
  localparam logic RETAIN_RESET = 1'b1;
  localparam logic [4:0] LEN_RESET = 5'h08;
  localparam logic [1:0] LEVEL_RESET = 2'h0;
  localparam logic [7:0] EDGE_FIXED = 8'h04;
  localparam logic [7:0] RSVD_ONES_VALUE = 8'hFF;
  localparam logic [7:0] PD_FIXED = 8'h80;
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;

  // Impedance field codes
  localparam logic [1:0] IMP_33 = 2'h0;
  localparam logic [1:0] IMP_85 = 2'h1;
  localparam logic [1:0] IMP_100 = 2'h2;

  // Disabled output level codes
  localparam logic [1:0] LVL_LOW_LOW = 2'h0;
  localparam logic [1:0] LVL_HIZ = 2'h1;
  localparam logic [1:0] LVL_HIGH_LOW = 2'h2;
  localparam logic [1:0] LVL_LOW_HIGH = 2'h3;

  // Identification codes (values arbitrary)
  localparam logic [3:0] REVISION_CODE = 4'h3;
  localparam logic [3:0] VENDOR_CODE = 4'hA;
  localparam logic [1:0] CLASS_CODE = 2'h2;
  localparam logic [5:0] PART_CODE = 6'h15;

  localparam int NUM_PAIRS = 7;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK} cbr_state_t;
  typedef enum logic [1:0] {RL_ADDR, RL_INDEX, RL_WCOUNT, RL_WDATA} cbr_role_t;
endpackage

// ==== rtl/cbr_regs.sv ====
// Serial-bus slave and configuration register bank, bytes 3 to 12
`timescale 1ns/1ns
// Summary of operation
// [R1] Byte 3 bit 0: output six edge rate
// [R2] Byte 4 always reads all ones
// [R3] Byte 5: fixed revision and vendor codes
// [R4] Byte 6: fixed class and part codes
// [R5] Byte 7: read-back length, resets to eight
// [R6] Bytes 8 and 9 have no function
// [R7] Byte 10 bit 6: keep config in power-down
// [R8] Byte 11 bits 1:0: disabled output level
// [R9] Two-bit impedance fields for outputs 0, 1, 2 and 6
// [R10] Impedance reset value set by variant
// [R11] Fixed reserved bits in bytes 3, 10
// [R12] Disabled output takes programmed level
// [R13] Block read sends count then data
// [R14] Read-only and reserved writes are ignored
module cbr_regs
  import cbr_pkg::*;
#(
  parameter logic [1:0] IMP_DEFAULT = IMP_100
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [6:0] slave_addr,
  input wire logic pwrgd_pd_n,
  input wire logic [NUM_PAIRS-1:0] output_enable,
  output logic output6_edge_rate_select,
  output logic [4:0] readback_length_field,
  output logic powerdown_config_retain,
  output logic [1:0] disabled_output_level,
  output logic [1:0] output6_drive_impedance,
  output logic [1:0] output2_drive_impedance,
  output logic [1:0] output1_drive_impedance,
  output logic [1:0] output0_drive_impedance,
  output logic [NUM_PAIRS-1:0] clock_output_pair_pass,
  output logic [NUM_PAIRS-1:0] clock_output_pair_true,
  output logic [NUM_PAIRS-1:0] clock_output_pair_comp,
  output logic [NUM_PAIRS-1:0] clock_output_pair_hiz
);
  logic rst_meta;
  logic rst_n;
  logic scl_s;
  logic sda_s;
  logic pd_n_s;
  logic scl_d;
  logic sda_d;
  logic pd_n_d;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic pd_enter;
  logic [6:0] addr_s;
  logic [1:0] addr_settle;
  logic [6:0] own_addr;
  logic addr_taken;
  cbr_state_t state;
  cbr_role_t role;
  logic [7:0] shreg;
  logic [2:0] bitcnt;
  logic ack_byte;
  logic read_dir;
  logic byte_done;
  logic [7:0] index;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] rd_data;

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Idle-high start values keep reset release free of false bus edges
  cbr_sync2 #(.WIDTH(3), .INIT(3'h7)) u_pin_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d({scl_i, sda_i, pwrgd_pd_n}),
    .q({scl_s, sda_s, pd_n_s})
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      pd_n_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      pd_n_d <= pd_n_s;
    end
  end

  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign bus_start = scl_s && scl_d && sda_d && !sda_s;
  assign bus_stop = scl_s && scl_d && !sda_d && sda_s;
  assign pd_enter = pd_n_d && !pd_n_s;
  // Ninth bus clock begins with eight bits gathered
  assign byte_done = scl_fall && bitcnt == 3'h0 && ack_byte;

  // Address strap is a pin too; caught once, after its synchroniser has filled
  cbr_sync2 #(.WIDTH(7), .INIT(7'h00)) u_addr_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d(slave_addr),
    .q(addr_s)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      own_addr <= 7'h00;
      addr_taken <= 1'b0;
      addr_settle <= 2'h0;
    end else if (!addr_taken) begin
      addr_settle <= {addr_settle[0], 1'b1};
      if (addr_settle[1]) begin
        own_addr <= addr_s;
        addr_taken <= 1'b1;
      end
    end
  end

  // Read data of the addressed byte
  always_comb begin
    case (index)
      ADDR_EDGE_RATE: rd_data = EDGE_FIXED | {7'h00, output6_edge_rate_select}; // [R1] [R11]
      ADDR_RSVD_ONES: rd_data = RSVD_ONES_VALUE; // [R2]
      ADDR_REV_VENDOR: rd_data = {REVISION_CODE, VENDOR_CODE}; // [R3]
      ADDR_CLASS_PART: rd_data = {CLASS_CODE, PART_CODE}; // [R4]
      ADDR_READBACK_LEN: rd_data = {3'h0, readback_length_field}; // [R5]
      ADDR_RSVD_EIGHT: rd_data = UNMAPPED_VALUE; // [R6]
      ADDR_RSVD_NINE: rd_data = UNMAPPED_VALUE; // [R6]
      ADDR_PD_RETAIN: rd_data = PD_FIXED | {1'b0, powerdown_config_retain, 6'h00}; // [R7] [R11]
      ADDR_IMP_LEVEL: rd_data = {output6_drive_impedance, 4'h0, disabled_output_level}; // [R8] [R9]
      ADDR_IMP_LOW: rd_data = {output2_drive_impedance, output1_drive_impedance, 2'h0,
                               output0_drive_impedance}; // [R9]
      // Bytes outside this bank read as zero
      default: rd_data = UNMAPPED_VALUE;
    endcase
  end

  // Bus protocol sequencing
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      role <= RL_ADDR;
      shreg <= 8'h00;
      bitcnt <= 3'h0;
      ack_byte <= 1'b0;
      read_dir <= 1'b0;
      index <= 8'h00;
      wr_en <= 1'b0;
      wr_data <= 8'h00;
      sda_oe <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      if (bus_stop) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (bus_start) begin
        state <= ST_RX;
        role <= RL_ADDR;
        bitcnt <= 3'h0;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_RX: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 3'h1;
            end
            // A fall with no byte gathered, such as the one after a start, is no ack slot
            if (byte_done && shreg_full(shreg, role, own_addr)) begin
              state <= ST_RX_ACK;
              sda_oe <= 1'b1;
              case (role)
                RL_ADDR: begin
                  read_dir <= shreg[0];
                  role <= RL_INDEX;
                end
                RL_INDEX: begin
                  index <= shreg;
                  role <= RL_WCOUNT;
                end
                RL_WCOUNT: begin
                  // Byte count is acked but not enforced
                  role <= RL_WDATA;
                end
                RL_WDATA: begin
                  wr_en <= 1'b1;
                  wr_data <= shreg;
                end
                default: role <= RL_ADDR;
              endcase
            end else if (byte_done) begin
              state <= ST_IDLE;
            end
            if (scl_rise && bitcnt == LAST_BIT) begin
              ack_byte <= 1'b1;
            end
          end
          ST_RX_ACK: begin
            ack_byte <= 1'b0;
            if (scl_fall) begin
              if (read_dir && role == RL_INDEX) begin
                // Block read opens with the byte count
                state <= ST_TX;
                shreg <= {3'h0, readback_length_field}; // [R13]
                sda_oe <= ({3'h0, readback_length_field} & 8'h80) == 8'h00;
                bitcnt <= 3'h0;
                role <= RL_ADDR;
              end else begin
                state <= ST_RX;
                sda_oe <= 1'b0;
                bitcnt <= 3'h0;
              end
            end
          end
          ST_TX: begin
            // Next bit leaves on each bus clock fall; the ninth clock is the host's
            if (scl_fall) begin
              if (bitcnt == LAST_BIT) begin
                state <= ST_TX_ACK;
                sda_oe <= 1'b0;
                bitcnt <= 3'h0;
              end else begin
                shreg <= {shreg[6:0], 1'b0};
                sda_oe <= !shreg[6];
                bitcnt <= bitcnt + 3'h1;
              end
            end
          end
          ST_TX_ACK: begin
            if (scl_rise) begin
              // Host not-acknowledge ends the block read
              ack_byte <= !sda_s; // [R13]
            end else if (scl_fall) begin
              if (ack_byte) begin
                state <= ST_TX;
                shreg <= rd_data;
                sda_oe <= !rd_data[7];
                // Step past the byte just loaded so the next ack fetches the following one
                index <= index + 8'h01; // [R13]
              end else begin
                state <= ST_IDLE;
              end
              ack_byte <= 1'b0;
            end
          end
          default: begin
            sda_oe <= 1'b0;
            ack_byte <= 1'b0;
          end
        endcase
      end
      if (wr_en) begin
        index <= index + 8'h01;
      end
    end
  end

  // Address byte must match; other bytes are always taken
  function automatic logic shreg_full(input logic [7:0] b, input cbr_role_t r, input logic [6:0] a);
    shreg_full = (r != RL_ADDR) || (b[7:1] == a);
  endfunction

  // Open-drain data line only ever pulls low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // Writable fields; unmapped, read-only and reserved bits drop writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      output6_edge_rate_select <= EDGE6_RESET; // [R1]
      readback_length_field <= LEN_RESET; // [R5]
      powerdown_config_retain <= RETAIN_RESET; // [R7]
      disabled_output_level <= LEVEL_RESET; // [R8]
      output6_drive_impedance <= IMP_DEFAULT; // [R10]
      output2_drive_impedance <= IMP_DEFAULT; // [R10]
      output1_drive_impedance <= IMP_DEFAULT; // [R10]
      output0_drive_impedance <= IMP_DEFAULT; // [R10]
    end else if (pd_enter && !powerdown_config_retain) begin
      // The retain bit itself returns to its reset value too
      output6_edge_rate_select <= EDGE6_RESET; // [R7]
      readback_length_field <= LEN_RESET;
      powerdown_config_retain <= RETAIN_RESET;
      disabled_output_level <= LEVEL_RESET;
      output6_drive_impedance <= IMP_DEFAULT;
      output2_drive_impedance <= IMP_DEFAULT;
      output1_drive_impedance <= IMP_DEFAULT;
      output0_drive_impedance <= IMP_DEFAULT;
    end else if (wr_en) begin
      case (index)
        ADDR_EDGE_RATE: output6_edge_rate_select <= wr_data[EDGE6_BIT]; // [R1] [R14]
        ADDR_READBACK_LEN: readback_length_field <= wr_data[LEN_MSB:0]; // [R5] [R14]
        ADDR_PD_RETAIN: powerdown_config_retain <= wr_data[RETAIN_BIT]; // [R7] [R14]
        ADDR_IMP_LEVEL: begin
          disabled_output_level <= wr_data[LEVEL_MSB:0]; // [R8]
          output6_drive_impedance <= wr_data[IMP6_LSB+:2]; // [R9]
        end
        ADDR_IMP_LOW: begin
          output2_drive_impedance <= wr_data[IMP2_LSB+:2]; // [R9]
          output1_drive_impedance <= wr_data[IMP1_LSB+:2]; // [R9]
          output0_drive_impedance <= wr_data[IMP0_LSB+:2]; // [R9]
        end
        default: begin
          output6_edge_rate_select <= output6_edge_rate_select; // [R2] [R6] [R14]
        end
      endcase
    end
  end

  // One drive controller per output pair
  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
    cbr_pair_ctl u_pair (
      .clk(ref_clk),
      .rst_n(rst_n),
      .enable(output_enable[p]), // [R12]
      .disabled_output_level(disabled_output_level),
      .pass(clock_output_pair_pass[p]),
      .true_lvl(clock_output_pair_true[p]),
      .comp_lvl(clock_output_pair_comp[p]),
      .hiz(clock_output_pair_hiz[p])
    );
  end
endmodule

// ==== rtl/cbr_sync2.sv ====
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ns
module cbr_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ==== testbench/cbr_host_model.sv ====
// Serial bus host model for the register bank
`timescale 1ns/1ns
module cbr_host_model #(
  parameter int HALF = 10
) (
  input wire logic ref_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // One bus clock; a released line floats high through the pull-up
  task automatic clk_bit(input logic b, output logic seen);
    tick(HALF / 2);
    sda_low <= !b;
    tick(HALF / 2);
    scl <= 1'b1;
    tick(HALF - 1);
    seen = sda;
    tick(1);
    scl <= 1'b0;
  endtask
  task automatic start();
    tick(HALF / 2);
    sda_low <= 1'b0;
    tick(HALF / 2);
    scl <= 1'b1;
    tick(HALF);
    sda_low <= 1'b1;
    tick(HALF);
    scl <= 1'b0;
  endtask
  task automatic stop();
    tick(HALF / 2);
    sda_low <= 1'b1;
    tick(HALF / 2);
    scl <= 1'b1;
    tick(HALF);
    sda_low <= 1'b0;
    tick(HALF);
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic get_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
    clk_bit(nack, s);
  endtask
endmodule

// ==== testbench/cbr_regs_asserts.sv ====
// Port assertions for the configuration register bank
`timescale 1ns/1ns
module cbr_regs_asserts
  import cbr_pkg::*;
#(
  parameter logic [1:0] IMP_DEFAULT = IMP_100
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic [6:0] slave_addr,
  input wire logic pwrgd_pd_n,
  input wire logic [NUM_PAIRS-1:0] output_enable,
  input wire logic output6_edge_rate_select,
  input wire logic [4:0] readback_length_field,
  input wire logic powerdown_config_retain,
  input wire logic [1:0] disabled_output_level,
  input wire logic [1:0] output6_drive_impedance,
  input wire logic [1:0] output2_drive_impedance,
  input wire logic [1:0] output1_drive_impedance,
  input wire logic [1:0] output0_drive_impedance,
  input wire logic [NUM_PAIRS-1:0] clock_output_pair_pass,
  input wire logic [NUM_PAIRS-1:0] clock_output_pair_true,
  input wire logic [NUM_PAIRS-1:0] clock_output_pair_comp,
  input wire logic [NUM_PAIRS-1:0] clock_output_pair_hiz
);
  localparam logic [16:0] DFLT = {EDGE6_RESET, RETAIN_RESET, LEN_RESET, LEVEL_RESET, {4{IMP_DEFAULT}}};
  logic [3:0] age;
  logic ok;
  logic [16:0] cfg;
  logic [1:0] lv;
  assign lv = disabled_output_level;
  assign ok = age == 4'hF;
  assign cfg = {output6_edge_rate_select, powerdown_config_retain, readback_length_field, lv,
    output6_drive_impedance, output2_drive_impedance, output1_drive_impedance, output0_drive_impedance};
  // Pair outputs are judged only once reset and power-down have long settled
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      age <= 4'h0;
    end else if (!pwrgd_pd_n) begin
      age <= 4'h0;
    end else if (age != 4'hF) begin
      age <= age + 4'h1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_reset;
    disable iff (1'b0) !resetn |=> cfg == DFLT && !sda_oe;
  endproperty
  a_reset: assert property (p_reset) else $error("config not at reset values");
  property p_clear;
    $fell(pwrgd_pd_n) && !powerdown_config_retain |-> ##[1:8] cfg == DFLT;
  endproperty
  a_clear: assert property (p_clear) else $error("power-down did not restore config");
  property p_keep;
    $fell(pwrgd_pd_n) && powerdown_config_retain |=> $stable(cfg) [*6];
  endproperty
  a_keep: assert property (p_keep) else $error("power-down lost config");
  property p_hl;
    (ok && !output_enable[0] && lv == LVL_HIGH_LOW) [*2] |-> clock_output_pair_true[0] && !clock_output_pair_comp[0];
  endproperty
  a_hl: assert property (p_hl) else $error("pair 0 not high/low");
  property p_lh;
    (ok && !output_enable[6] && lv == LVL_LOW_HIGH) [*2] |->
      !clock_output_pair_true[6] && clock_output_pair_comp[6] && !clock_output_pair_pass[6];
  endproperty
  a_lh: assert property (p_lh) else $error("pair 6 not low/high");
  property p_hiz;
    (ok && !output_enable[0] && lv == LVL_HIZ) [*2] |-> clock_output_pair_hiz[0] && !clock_output_pair_true[0];
  endproperty
  a_hiz: assert property (p_hiz) else $error("pair 0 not floating");
  property p_ll;
    (ok && !output_enable[6] && lv == LVL_LOW_LOW) [*2] |->
      !clock_output_pair_true[6] && !clock_output_pair_comp[6] && !clock_output_pair_hiz[6];
  endproperty
  a_ll: assert property (p_ll) else $error("pair 6 not low/low");
  property p_on;
    (ok && output_enable[1]) [*2] |-> clock_output_pair_pass[1] && !clock_output_pair_hiz[1];
  endproperty
  a_on: assert property (p_on) else $error("enabled pair 1 not passing");
  property p_drive;
    $rose(sda_oe) |-> !scl_i && !sda_o;
  endproperty
  a_drive: assert property (p_drive) else $error("data driven while bus clock high");
  c_clear: cover property ($fell(pwrgd_pd_n) && !powerdown_config_retain);
  c_hiz: cover property (clock_output_pair_hiz[0]);
  c_drive: cover property ($rose(sda_oe));
endmodule
bind cbr_regs cbr_regs_asserts #(.IMP_DEFAULT(IMP_DEFAULT)) u_asserts (.*);

// ==== testbench/test_clock_buffer_config_regs.sv ====
// Self-checking bench for the configuration register bank
`timescale 1ns/1ns
module test_clock_buffer_config_regs;
  import cbr_pkg::*;
  localparam logic [6:0] ADR = 7'h5A;
  localparam logic [1:0] ID = IMP_100;
  localparam logic [19:0] DFLT = {3'h0, EDGE6_RESET, RETAIN_RESET, LEN_RESET, LEVEL_RESET, {4{ID}}};
  localparam logic [7:0] B5 = {REVISION_CODE, VENDOR_CODE};
  localparam logic [7:0] B6 = {CLASS_CODE, PART_CODE};
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic pwrgd_pd_n = 1'b1;
  logic [6:0] oe = 7'h7F;
  logic scl, hlow, sda_o, sda_oe, e6, ret;
  logic [4:0] len;
  logic [1:0] lvl, z6, z2, z1, z0;
  logic [6:0] pass, ptru, pcmp, phiz;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  wire sda = !(hlow || (sda_oe && !sda_o));
  always #2 ref_clk = ~ref_clk;
  cbr_regs #(.IMP_DEFAULT(ID)) dut (.ref_clk(ref_clk), .resetn(resetn), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .slave_addr(ADR), .pwrgd_pd_n(pwrgd_pd_n), .output_enable(oe),
    .output6_edge_rate_select(e6), .readback_length_field(len), .powerdown_config_retain(ret),
    .disabled_output_level(lvl), .output6_drive_impedance(z6), .output2_drive_impedance(z2),
    .output1_drive_impedance(z1), .output0_drive_impedance(z0), .clock_output_pair_pass(pass),
    .clock_output_pair_true(ptru), .clock_output_pair_comp(pcmp), .clock_output_pair_hiz(phiz));
  cbr_host_model host (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(hlow));
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  function automatic logic [19:0] cfg();
    return {3'h0, e6, ret, len, lvl, z6, z2, z1, z0};
  endfunction
  task automatic wr(input logic [7:0] idx, input logic [7:0] d[$]);
    logic a;
    host.start();
    host.put_byte({ADR, 1'b0}, a);
    chk("address ack", 20'h1, 20'(a));
    host.put_byte(idx, a);
    host.put_byte(8'(d.size()), a);
    foreach (d[i]) host.put_byte(d[i], a);
    host.stop();
    tick(8);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] cnt, input logic [7:0] exp[$]);
    logic a;
    logic [7:0] b;
    host.start();
    host.put_byte({ADR, 1'b0}, a);
    host.put_byte(idx, a);
    host.start();
    host.put_byte({ADR, 1'b1}, a);
    host.get_byte(1'b0, b);
    chk("count byte", 20'(cnt), 20'(b));
    foreach (exp[i]) begin
      host.get_byte(i == exp.size() - 1, b);
      chk($sformatf("byte %0d", idx + i), 20'(exp[i]), 20'(b));
    end
    host.stop();
    tick(8);
  endtask
  task automatic t_reset();
    chk("config", DFLT, cfg());
    rd(8'h03, 8'h08, '{8'h05, 8'hFF, B5, B6, 8'h08, 8'h00, 8'h00, 8'hC0, {ID, 6'h00}, {ID, ID, 2'h0, ID}});
  endtask
  task automatic t_write();
    wr(8'h03, '{8'hFE, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h7E, 8'h11});
    chk("config", {5'h0, 5'h1F, LVL_HIGH_LOW, IMP_85, IMP_33, IMP_85, IMP_85}, cfg());
    rd(8'h03, 8'h1F, '{8'h04, 8'hFF, B5, B6, 8'h1F, 8'h00, 8'h00, 8'h80, 8'h42, 8'h11});
  endtask
  task automatic t_pd();
    pwrgd_pd_n <= 1'b0;
    tick(12);
    chk("cleared", DFLT, cfg());
    pwrgd_pd_n <= 1'b1;
    tick(12);
    wr(8'h03, '{8'h00});
    pwrgd_pd_n <= 1'b0;
    tick(12);
    chk("kept", DFLT ^ 20'h10000, cfg());
    pwrgd_pd_n <= 1'b1;
    tick(12);
  endtask
  task automatic t_lvl();
    for (int c = 0; c < 4; c++) begin
      wr(8'h0B, '{{ID, 4'h0, 2'(c)}});
      oe <= 7'h3E;
      tick(4);
      chk("pair 0", {16'h0, 1'b0, c == 2, c == 3, c == 1},
          {16'h0, pass[0], ptru[0], pcmp[0], phiz[0]});
      chk("pass", 20'h3E, 20'(pass));
      oe <= 7'h7F;
    end
  endtask
  task automatic t_imp();
    logic [1:0] codes[3];
    logic [1:0] c;
    codes = '{IMP_33, IMP_85, IMP_100};
    for (int i = 0; i < 3; i++) begin
      c = codes[i];
      wr(8'h0B, '{{c, 6'h00}, {c, c, 2'h0, c}});
      chk("impedance", 20'({c, c, c, c}), 20'({z6, z2, z1, z0}));
    end
  endtask
  task automatic t_addr();
    logic a;
    host.start();
    host.put_byte({ADR ^ 7'h01, 1'b0}, a);
    chk("foreign ack", 20'h0, 20'(a));
    host.stop();
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    tick(6);
    resetn <= 1'b1;
    tick(12);
    t_reset();
    t_write();
    t_pd();
    t_lvl();
    t_imp();
    t_addr();
    close_out();
  end
endmodule
